//--- dv/nsu_meas_model.sv
// Behavioural three-phase current source giving phasor samples.
// Driven by the bench through send; same clock as the element.
module nsu_meas_model
    import nsu_pkg::*;
(
    // Clock
    input  wire logic           clk_i,
    // Samples
    output logic                sample_valid_o,
    output nsu_pkg::nsu_phases_s phases_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sample_valid_o = 1'b0;
        phases_o       = '0;
    end

    // Balanced part in ABC order plus extra on phase a
    task automatic send(input int amp, input int extra, input bit bal);
        int h;
        int s;
        h = bal ? -amp / 2 : 0;
        s = bal ? (amp * 32'h6EDA) >>> 15 : 0;
        @(posedge clk_i);
        sample_valid_o <= 1'b1;
        phases_o       <= '{'{16'(amp + extra), 16'h0}, '{16'(h), 16'(-s)}, '{16'(h), 16'(s)}};
        @(posedge clk_i);
        sample_valid_o <= 1'b0;
        // Stale values would hide a late capture
        phases_o       <= ~phases_o;
    endtask : send
endmodule : nsu_meas_model

//--- dv/nsu_trip_bench.sv
// Self-checking bench for the unbalance trip element.
// Drives the register bus and the behavioural current source.
module nsu_trip_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import nsu_pkg::*;

    typedef struct packed {
        logic [4:0]  ctrl;
        logic [15:0] amp;
        logic [15:0] extra;
        logic        bal;
        logic        pick;
    } nsu_row_s;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic        prot_reset_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sample_valid_i;
    logic        pickup_o;
    logic        trip_o;
    logic        irq_o;
    nsu_phases_s phases_i;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;
    int          first;
    logic [31:0] rd;
    logic [7:0]  radr [10] = '{ADR_CTRL, ADR_NOMINAL, ADR_THRESH, ADR_RATIO, ADR_DELAY, ADR_CAPAB,
        ADR_HSCALE, ADR_DECAY, ADR_IRQ_MASK, 8'h30};
    logic [31:0] rexp [10] = '{32'h0, 32'h1000, 32'h1A, 32'h14, 32'h400, 32'h1000, 32'h100, 32'h10,
        32'h0, 32'h0};
    // Nominal 0x800, threshold 1.0: single phase picks up above 0x1800
    nsu_row_s    rows [8] = '{'{5'h01, 16'h1800, 16'h0, 1'b0, 1'b0}, '{5'h01, 16'h1801, 16'h0, 1'b0, 1'b1},
        '{5'h00, 16'h4E20, 16'h0, 1'b0, 1'b0}, '{5'h05, 16'h4E20, 16'h0, 1'b0, 1'b1},
        '{5'h05, 16'h4E20, 16'h19C8, 1'b1, 1'b0}, '{5'h01, 16'h4E20, 16'h19C8, 1'b1, 1'b1},
        '{5'h01, 16'h1770, 16'h0, 1'b1, 1'b0}, '{5'h09, 16'h1770, 16'h0, 1'b1, 1'b1}};

    nsu_meas_model u_meas (.clk_i, .sample_valid_o(sample_valid_i), .phases_o(phases_i));
    nsu_trip u_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_valid_i, .phases_i, .prot_reset_i, .pickup_o,
        .trip_o, .irq_o);

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic final_report;
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check(32'(n < 20), 32'h1, "bus ack");
    endtask : wb

    // Decision is settled well within four edges of the strobe
    task automatic smp(input int amp, input int extra, input bit bal);
        u_meas.send(amp, extra, bal);
        repeat (4) @(posedge clk_i);
        #1;
    endtask : smp

    task automatic heat(input int maxn, output int f);
        f = 0;
        for (int n = 1; n <= maxn; n++)
        begin
            smp(32'h3000, 0, 1'b0);
            if (f == 0 && trip_o === 1'b1)
                f = n;
        end
    endtask : heat

    task automatic prot;
        @(posedge clk_i);
        prot_reset_i <= 1'b1;
        @(posedge clk_i);
        prot_reset_i <= 1'b0;
        #1;
    endtask : prot

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_count++;
            $display("ERROR %0t run too long", $time);
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 8'h30, 32'hFFFF_FFFF);
        for (int i = 0; i < 10; i++)
        begin
            wb(1'b0, radr[i], 32'h0);
            check(rd, rexp[i], "reset value");
        end
        wb(1'b1, ADR_NOMINAL, 32'h800);
        wb(1'b1, ADR_THRESH, 32'h100);
        wb(1'b1, ADR_DELAY, 32'h64);
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, ADR_CTRL, 32'(rows[i].ctrl));
            smp(rows[i].amp, rows[i].extra, rows[i].bal);
            check(32'(pickup_o), 32'(rows[i].pick), "pickup row");
        end
        wb(1'b1, ADR_DELAY, 32'h4);
        wb(1'b1, ADR_CTRL, 32'h1);
        prot();
        // A dip at the fourth sample restarts the count
        for (int i = 1; i <= 8; i++)
        begin
            smp(i == 4 ? 0 : 32'h2000, 0, 1'b0);
            check(32'(trip_o), 32'(i == 8), "definite delay");
        end
        check(32'(irq_o), 32'h0, "masked irq");
        wb(1'b1, ADR_IRQ_MASK, 32'h2);
        check(32'(irq_o), 32'h1, "unmasked irq");
        wb(1'b1, ADR_IRQ_STAT, 32'h2);
        check(32'(irq_o), 32'h0, "cleared irq");
        wb(1'b0, ADR_IRQ_STAT, 32'h0);
        check(rd, 32'h1, "irq status");
        wb(1'b0, ADR_STATUS, 32'h0);
        check(rd, 32'h7, "status word");
        wb(1'b0, ADR_I2_MAG, 32'h0);
        check(rd, 32'h4, "negative sequence magnitude");
        prot();
        check(32'({pickup_o, trip_o}), 32'h0, "prot reset");
        smp(32'h2000, 0, 1'b0);
        check(32'(trip_o), 32'h0, "timer cleared");
        wb(1'b1, ADR_CAPAB, 32'h1E);
        wb(1'b1, ADR_CTRL, 32'h3);
        prot();
        heat(14, first);
        check(32'(first >= 10 && first <= 12), 32'h1, "cold inverse");
        smp(0, 0, 1'b0);
        smp(0, 0, 1'b0);
        heat(3, first);
        check(32'(first), 32'h1, "warm inverse");
        wb(1'b1, ADR_DECAY, 32'h8000);
        smp(0, 0, 1'b0);
        heat(8, first);
        check(32'(first >= 2 && first <= 6), 32'h1, "partial cooling");
        for (int i = 0; i < 40; i++)
            smp(0, 0, 1'b0);
        heat(14, first);
        check(32'(first >= 10 && first <= 12), 32'h1, "cooled to cold");
        wb(1'b1, ADR_CTRL, 32'h2);
        prot();
        heat(12, first);
        check(32'(first), 32'h0, "disabled no trip");
        wb(1'b1, ADR_CTRL, 32'h3);
        heat(1, first);
        check(32'(first), 32'h1, "heat while disabled");
        wb(1'b1, ADR_CTRL, 32'h13);
        heat(1, first);
        check(32'(first), 32'h0, "reset clears heat");
        // Frozen clock enable must swallow a whole sample
        @(posedge clk_i);
        ce_i <= 1'b0;
        smp(0, 0, 1'b0);
        check(32'(pickup_o), 32'h1, "clock enable freeze");
        @(posedge clk_i);
        ce_i <= 1'b1;
        final_report();
    end
endmodule : nsu_trip_bench

//--- dv/nsu_trip_sva.sv
// Port assertions for the unbalance trip element.
// Bound into every nsu_trip instance; one clock domain.
module nsu_trip_sva
(
    // Clock, reset, enable
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Element
    input wire logic        sample_valid_i,
    input wire logic        prot_reset_i,
    input wire logic        pickup_o,
    input wire logic        trip_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack_next;
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_single;
        ce_i && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack too long");
    property p_wr_zero;
        wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write data not zero");
    property p_trip_pickup;
        trip_o |-> pickup_o;
    endproperty
    a_trip_pickup: assert property (p_trip_pickup) else $error("trip without pickup");
    // Decisions only move after a sample, a reset or a control write
    property p_pickup_cause;
        $changed(pickup_o) |-> $past(sample_valid_i, 3) || $past(sample_valid_i, 4) || $past(prot_reset_i)
            || wb_ack_o;
    endproperty
    a_pickup_cause: assert property (p_pickup_cause) else $error("pickup moved alone");
    property p_trip_rise;
        $rose(trip_o) |-> $past(sample_valid_i, 3) || $past(sample_valid_i, 4);
    endproperty
    a_trip_rise: assert property (p_trip_rise) else $error("trip rose alone");
    property p_prot_clear;
        ce_i && prot_reset_i |=> !pickup_o && !trip_o;
    endproperty
    a_prot_clear: assert property (p_prot_clear) else $error("prot reset ignored");
    property p_irq_rise;
        $rose(irq_o) |-> $rose(pickup_o) || $rose(trip_o) || wb_ack_o;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
    property p_irq_fall;
        $fell(irq_o) |-> wb_ack_o;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule : nsu_trip_sva

bind nsu_trip nsu_trip_sva u_sva (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .wb_dat_o, .sample_valid_i, .prot_reset_i, .pickup_o, .trip_o, .irq_o);

//--- hw/nsu_pkg.sv
// Package for the negative sequence unbalance trip element.
// Assumes a 50 MHz system clock and phasor samples from the measurement chain on the same clock.
package nsu_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0]  ADR_CTRL     = 8'h00;
    localparam logic [7:0]  ADR_NOMINAL  = 8'h04;
    localparam logic [7:0]  ADR_THRESH   = 8'h08;
    localparam logic [7:0]  ADR_RATIO    = 8'h0C;
    localparam logic [7:0]  ADR_DELAY    = 8'h10;
    localparam logic [7:0]  ADR_CAPAB    = 8'h14;
    localparam logic [7:0]  ADR_HSCALE   = 8'h18;
    localparam logic [7:0]  ADR_DECAY    = 8'h1C;
    localparam logic [7:0]  ADR_STATUS   = 8'h20;
    localparam logic [7:0]  ADR_IRQ_STAT = 8'h24;
    localparam logic [7:0]  ADR_IRQ_MASK = 8'h28;
    localparam logic [7:0]  ADR_I2_MAG   = 8'h2C;

    // Control register fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_INV_BIT   = 1;
    localparam int CTRL_RATIO_BIT = 2;
    localparam int CTRL_ACB_BIT   = 3;
    localparam int CTRL_RESET_BIT = 4;
    localparam int CTRL_W         = 4;

    // Interrupt status and mask fields
    localparam int IRQ_PICKUP_BIT = 0;
    localparam int IRQ_TRIP_BIT   = 1;
    localparam int IRQ_W          = 2;

    // Values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
    localparam logic [15:0]       NOM_RST    = 16'h1000;
    localparam logic [15:0]       THR_RST    = 16'h001A;
    localparam logic [6:0]        RATIO_RST  = 7'h14;
    localparam logic [31:0]       DELAY_RST  = 32'h0000_0400;
    localparam logic [31:0]       CAPAB_RST  = 32'h0000_1000;
    localparam logic [15:0]       HSCALE_RST = 16'h0100;
    localparam logic [15:0]       DECAY_RST  = 16'h0010;
    localparam logic [IRQ_W-1:0]  IRQ_RST    = 2'h0;

    // Arithmetic constants
    localparam logic signed [16:0] SQRT3_HALF_Q15 = 17'sh06EDA;
    localparam int                 SQRT3_SHIFT    = 15;
    localparam int                 THR_FRAC       = 8;
    localparam int                 HSCALE_FRAC    = 8;
    localparam int                 DECAY_FRAC     = 16;
    localparam logic [1:0]         SEQ_GAIN       = 2'h3;
    localparam logic [13:0]        PCT_FULL_SQ    = 14'h2710;
    localparam logic [6:0]         COOL_STOP_DIV  = 7'h64;
    localparam int                 SQ_W           = 56;
    localparam int                 TH_W           = 72;

    typedef logic [SQ_W-1:0] nsu_sq_t;
    typedef logic [TH_W-1:0] nsu_theta_t;

    typedef struct packed {
        logic signed [15:0] re;
        logic signed [15:0] im;
    } nsu_phasor_s;

    typedef struct packed {
        nsu_phasor_s a;
        nsu_phasor_s b;
        nsu_phasor_s c;
    } nsu_phases_s;

    typedef enum logic [2:0] {
        NSU_TH_COLD = 3'b001,
        NSU_TH_HEAT = 3'b010,
        NSU_TH_COOL = 3'b100
    } nsu_th_state_e;

endpackage : nsu_pkg

//--- hw/nsu_trip.sv
// Negative sequence overcurrent (unbalance) trip element with Wishbone registers.
// Assumes phasor samples on clk_i with a one-cycle valid strobe, and a global protection reset pulse.
// What this block does
// - Derive positive and negative sequence currents, honouring configured phase rotation.
// - Threshold is a minimum level; no trip at or below it.
// - Unbalance ratio negative over positive sequence compared with the ratio pickup.
// - Definite time trip only when all enabled conditions hold continuously for the delay; inverse trip needs them on the tripping sample only.
// - Threshold setting is a multiple of nominal current.
// - Definite time curve uses the programmed delay directly.
// - Inverse thermal curve derives the delay from the thermal state.
// - Thermal state updates always, independent of pickup or trip.
// - Inverse curve also needs thermal energy above a capability-derived maximum.
// - Cold inverse delay equals capability over excess squared per-unit current.
// - Residual heat shortens the inverse delay.
// - Above threshold, integrate squared current in excess of the squared threshold times a scaling factor.
// - Heating starts from energy left by cooling, or zero.
// - Below threshold, decay energy exponentially with the cooling constant.
// - Energy under one hundredth of maximum is cleared and cooling stops.
// - Thermal energy stays internal, never readable.
// - Global protection reset returns the element to idle with timers cleared.
// - Every instance has identical structure with its own settings and state.
module nsu_trip
    import nsu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Measurement samples
    input  wire logic                 sample_valid_i,
    input  wire nsu_pkg::nsu_phases_s phases_i,
    // Global protection reset
    input  wire logic                 prot_reset_i,
    // Decisions
    output logic                      pickup_o,
    output logic                      trip_o,
    output logic                      irq_o
);
    import nsu_pkg::*;

    // All state below is local, so each instance is self-contained

    // Settings
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       nominal;
    logic [15:0]       neg_seq_threshold;
    logic [6:0]        unbalance_ratio_pickup;
    logic [31:0]       delay;
    logic [31:0]       capab;
    logic [15:0]       hscale;
    logic [15:0]       decay;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_stat;

    // Bus decode
    logic        ack;
    logic [31:0] wmask;
    wire         bus_req  = wb_cyc_i & wb_stb_i & ~ack;
    wire         bus_wr   = bus_req & wb_we_i;
    wire         hit_ctrl = wb_adr_i == ADR_CTRL;
    wire         hit_nom  = wb_adr_i == ADR_NOMINAL;
    wire         hit_thr  = wb_adr_i == ADR_THRESH;
    wire         hit_rat  = wb_adr_i == ADR_RATIO;
    wire         hit_dly  = wb_adr_i == ADR_DELAY;
    wire         hit_cap  = wb_adr_i == ADR_CAPAB;
    wire         hit_hsc  = wb_adr_i == ADR_HSCALE;
    wire         hit_dec  = wb_adr_i == ADR_DECAY;
    wire         hit_sts  = wb_adr_i == ADR_STATUS;
    wire         hit_ist  = wb_adr_i == ADR_IRQ_STAT;
    wire         hit_imk  = wb_adr_i == ADR_IRQ_MASK;
    wire         hit_mag  = wb_adr_i == ADR_I2_MAG;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | (wb_dat_i & wmask);
    endfunction : merge

    wire en       = ctrl[CTRL_EN_BIT];
    wire inv_mode = ctrl[CTRL_INV_BIT];
    wire ratio_en = ctrl[CTRL_RATIO_BIT];
    wire acb      = ctrl[CTRL_ACB_BIT];
    // Self-clearing command bit, acts only on the write edge
    wire prot_clr = prot_reset_i | (bus_wr & hit_ctrl & wb_sel_i[0] & wb_dat_i[CTRL_RESET_BIT]);

    // Sample capture
    nsu_phases_s ph;
    logic        s0_vld;

    // Sequence components, scaled by 3 to avoid a divider
    wire signed [19:0] ar  = 20'(ph.a.re);
    wire signed [19:0] ai  = 20'(ph.a.im);
    wire signed [19:0] br  = 20'(ph.b.re);
    wire signed [19:0] bi  = 20'(ph.b.im);
    wire signed [19:0] cr  = 20'(ph.c.re);
    wire signed [19:0] ci  = 20'(ph.c.im);
    wire signed [19:0] hr  = (br + cr) >>> 1;
    wire signed [19:0] hi  = (bi + ci) >>> 1;
    wire signed [36:0] pr  = (bi - ci) * SQRT3_HALF_Q15;
    wire signed [36:0] pi  = (br - cr) * SQRT3_HALF_Q15;
    wire signed [19:0] rr  = 20'(pr >>> SQRT3_SHIFT);
    wire signed [19:0] ri  = 20'(pi >>> SQRT3_SHIFT);
    wire signed [19:0] re_p = ar - hr + rr;
    wire signed [19:0] im_p = ai - hi - ri;
    wire signed [19:0] re_m = ar - hr - rr;
    wire signed [19:0] im_m = ai - hi + ri;
    wire signed [39:0] sq_rp = re_p * re_p;
    wire signed [39:0] sq_ip = im_p * im_p;
    wire signed [39:0] sq_rm = re_m * re_m;
    wire signed [39:0] sq_im = im_m * im_m;
    wire nsu_sq_t      mag_p = SQ_W'(unsigned'(sq_rp)) + SQ_W'(unsigned'(sq_ip));
    wire nsu_sq_t      mag_m = SQ_W'(unsigned'(sq_rm)) + SQ_W'(unsigned'(sq_im));
    // Reversed rotation swaps the roles of the two sequences
    wire nsu_sq_t      next_i2sq = acb ? mag_m : mag_p;
    wire nsu_sq_t      next_i1sq = acb ? mag_p : mag_m;

    // Squared magnitudes per sample
    nsu_sq_t i2sq;
    nsu_sq_t i1sq;
    logic    s1_vld;

    // Threshold in measurement units: setting times nominal
    wire [31:0]  thr_full = nominal * neg_seq_threshold;
    wire [25:0]  thr3     = 26'(thr_full[31:THR_FRAC]) * 26'(SEQ_GAIN);
    wire nsu_sq_t thrsq   = SQ_W'(thr3) * SQ_W'(thr3);
    // Strictly above: equal magnitude never picks up
    wire         i2_above = i2sq > thrsq;
    // Ratio test without division: i2^2 * 100^2 > pct^2 * i1^2
    wire [13:0]  pct_sq   = 14'(unbalance_ratio_pickup) * 14'(unbalance_ratio_pickup);
    wire [71:0]  ratio_l  = 72'(i2sq) * 72'(PCT_FULL_SQ);
    wire [71:0]  ratio_r  = 72'(pct_sq) * 72'(i1sq);
    wire         ratio_ok = ratio_l > ratio_r;
    wire         pickup_w = en & i2_above & (~ratio_en | ratio_ok);

    // Thermal limit: capability in samples times nominal squared, same scale as i2sq
    // Operands widened first so neither product wraps at its own width
    wire [35:0]      nom9sq    = 36'(nominal) * 36'(nominal) * 36'(SEQ_GAIN) * 36'(SEQ_GAIN);
    wire nsu_theta_t theta_max = TH_W'(capab) * TH_W'(nom9sq);

    // Thermal state
    nsu_th_state_e th_state;
    nsu_th_state_e next_th_state;
    nsu_theta_t    theta;
    nsu_theta_t    next_theta;

    // Heating integrates the excess over threshold, so a cold start trips after
    // capability / (i2^2 - thr^2) samples
    wire nsu_sq_t    excess   = i2_above ? (i2sq - thrsq) : '0;
    wire [71:0]      inc_full = 72'(excess) * 72'(hscale);
    wire nsu_theta_t inc      = inc_full >> HSCALE_FRAC;
    wire [72:0]      heat_sum = {1'b0, theta} + {1'b0, inc};
    // Saturate instead of wrapping so a long fault can never look cold
    wire nsu_theta_t theta_heat = heat_sum[TH_W] ? '1 : heat_sum[TH_W-1:0];
    // Per-sample decay factor is precomputed by software as 1 - exp(-Ts/tau)
    wire [87:0]      drop_full  = 88'(theta) * 88'(decay);
    wire nsu_theta_t theta_cool = theta - TH_W'(drop_full >> DECAY_FRAC);
    wire [78:0]      cool_x100  = 79'(theta_cool) * 79'(COOL_STOP_DIV);
    wire             cool_done  = cool_x100 < 79'(theta_max);

    always_comb
    begin
        next_th_state = th_state;
        next_theta    = theta;
        case (th_state)
            NSU_TH_COLD:
            begin
                if (i2_above)
                begin
                    next_th_state = NSU_TH_HEAT;
                    next_theta    = inc;
                end
                else
                begin
                    next_theta = '0;
                end
            end
            NSU_TH_HEAT:
            begin
                if (i2_above)
                begin
                    next_theta = theta_heat;
                end
                else
                begin
                    next_th_state = NSU_TH_COOL;
                    next_theta    = theta_cool;
                end
            end
            NSU_TH_COOL:
            begin
                if (i2_above)
                begin
                    // Residual heat carries over, giving an earlier trip
                    next_th_state = NSU_TH_HEAT;
                    next_theta    = theta_heat;
                end
                else if (cool_done)
                begin
                    next_th_state = NSU_TH_COLD;
                    next_theta    = '0;
                end
                else
                begin
                    next_theta = theta_cool;
                end
            end
            default:
            begin
                next_th_state = NSU_TH_COLD;
                next_theta    = '0;
            end
        endcase
    end

    // Definite time counter of consecutive pickup samples
    logic [31:0] dcnt;
    wire  [32:0] held      = {1'b0, dcnt} + 33'h1;
    wire  [31:0] next_dcnt = ~pickup_w ? 32'h0 : (&dcnt ? dcnt : held[31:0]);
    wire         def_trip  = pickup_w & (held >= {1'b0, delay});
    wire         inv_trip  = pickup_w & (theta > theta_max);
    wire         next_trip = inv_mode ? inv_trip : def_trip;

    // Interrupt events on rising pickup and trip
    wire [IRQ_W-1:0] irq_set  = {next_trip & ~trip_o, pickup_w & ~pickup_o} & {IRQ_W{s1_vld & ~prot_clr}};
    wire [IRQ_W-1:0] irq_clr  = (bus_wr & hit_ist & wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;
    // Set beats a simultaneous write-one-to-clear
    wire [IRQ_W-1:0] next_ist = (irq_stat & ~irq_clr) | irq_set;

    // Read data; thermal energy deliberately has no address
    wire [31:0] rd_sts = {29'h0, th_state == NSU_TH_HEAT, trip_o, pickup_o};
    wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl) :
                         hit_nom  ? 32'(nominal) :
                         hit_thr  ? 32'(neg_seq_threshold) :
                         hit_rat  ? 32'(unbalance_ratio_pickup) :
                         hit_dly  ? delay :
                         hit_cap  ? capab :
                         hit_hsc  ? 32'(hscale) :
                         hit_dec  ? 32'(decay) :
                         hit_sts  ? rd_sts :
                         hit_ist  ? 32'(irq_stat) :
                         hit_imk  ? 32'(irq_mask) :
                         hit_mag  ? i2sq[SQ_W-1 -: 32] :
                         32'h0;

    // Wishbone answer: one cycle after the request, unmapped reads give zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack      <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else if (ce_i)
        begin
            ack <= bus_req;
            if (bus_req)
                wb_dat_o <= wb_we_i ? 32'h0 : rd_mux;
        end
    end

    assign wb_ack_o = ack;

    // Settings registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl                   <= CTRL_RST;
            nominal                <= NOM_RST;
            neg_seq_threshold      <= THR_RST;
            unbalance_ratio_pickup <= RATIO_RST;
            delay                  <= DELAY_RST;
            capab                  <= CAPAB_RST;
            hscale                 <= HSCALE_RST;
            decay                  <= DECAY_RST;
            irq_mask               <= IRQ_RST;
        end
        else if (ce_i && bus_wr)
        begin
            if (hit_ctrl) ctrl                   <= CTRL_W'(merge(32'(ctrl)));
            if (hit_nom)  nominal                <= 16'(merge(32'(nominal)));
            if (hit_thr)  neg_seq_threshold      <= 16'(merge(32'(neg_seq_threshold)));
            if (hit_rat)  unbalance_ratio_pickup <= 7'(merge(32'(unbalance_ratio_pickup)));
            if (hit_dly)  delay                  <= merge(delay);
            if (hit_cap)  capab                  <= merge(capab);
            if (hit_hsc)  hscale                 <= 16'(merge(32'(hscale)));
            if (hit_dec)  decay                  <= 16'(merge(32'(decay)));
            if (hit_imk)  irq_mask               <= IRQ_W'(merge(32'(irq_mask)));
        end
    end

    // Sample pipeline
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ph     <= '0;
            s0_vld <= 1'b0;
            i2sq   <= '0;
            i1sq   <= '0;
            s1_vld <= 1'b0;
        end
        else if (ce_i)
        begin
            s0_vld <= sample_valid_i;
            s1_vld <= s0_vld;
            if (sample_valid_i)
                ph <= phases_i;
            if (s0_vld)
            begin
                i2sq <= next_i2sq;
                i1sq <= next_i1sq;
            end
        end
    end

    // Thermal state runs every sample whatever the element's enable or trip
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && prot_clr))
        begin
            th_state <= NSU_TH_COLD;
            theta    <= '0;
        end
        else if (ce_i && s1_vld)
        begin
            th_state <= next_th_state;
            theta    <= next_theta;
        end
    end

    // Decision timers
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && prot_clr))
        begin
            dcnt     <= 32'h0;
            pickup_o <= 1'b0;
            trip_o   <= 1'b0;
        end
        else if (ce_i && s1_vld)
        begin
            dcnt     <= next_dcnt;
            pickup_o <= pickup_w;
            trip_o   <= next_trip;
        end
    end

    // Interrupt status
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat <= IRQ_RST;
        else if (ce_i)
            irq_stat <= next_ist;
    end

    assign irq_o = |(irq_stat & irq_mask);

endmodule : nsu_trip
